// ===== src/irq_vec_pkg.sv
// Purpose: Shared constants and types for the interrupt vector controller.
// Assumes: Seventeen maskable sources, one system clock.
// Notes:   Offsets are Wishbone byte addresses of 32-bit registers.
package irq_vec_pkg;
    localparam int NSRC = 17;
    localparam int IDXW = 5;
    localparam int VECW = 16;

    localparam logic [7:0] OFS_ENABLE   = 8'h00;
    localparam logic [7:0] OFS_PRIORITY = 8'h04;
    localparam logic [7:0] OFS_PENDSET  = 8'h08;
    localparam logic [7:0] OFS_PENDCLR  = 8'h0C;
    localparam logic [7:0] OFS_STATE    = 8'h10;
    localparam logic [7:0] OFS_EVSTAT   = 8'h14;
    localparam logic [7:0] OFS_EVCLR    = 8'h18;
    localparam logic [7:0] OFS_EVEN     = 8'h1C;

    localparam int GLOBAL_EN_BIT = 31;
    localparam int EXT0_IDX      = 0;
    localparam int EXT1_IDX      = 2;
    localparam int EV_CALL_BIT   = 0;
    localparam int EV_RET_BIT    = 1;
    localparam int NEV           = 2;

    localparam logic [NSRC-1:0] HW_CLEAR_MASK = 17'h0000F;
    localparam logic [NSRC-1:0] ENABLE_RST    = 17'h00000;
    localparam logic [NSRC-1:0] PRIORITY_RST  = 17'h00000;
    localparam logic [NSRC-1:0] PENDING_RST   = 17'h00000;

    localparam logic [VECW-1:0] VEC_BASE   = 16'h0003;
    localparam int              VEC_STRIDE = 8;

    localparam logic [2:0] CALL_CYCLES = 3'h5;

    typedef enum logic [1:0] {ST_IDLE, ST_CALL, ST_RETHOLD} seq_e;

    typedef struct packed {
        logic            req;
        logic            high;
        logic [VECW-1:0] vector;
    } call_s;
endpackage

// ===== src/irq_vector_ctrl.sv
// Purpose: Interrupt priority resolution and vector call generation.
// Assumes: Core pulses instrDone per finished instruction, retDone per
//          finished return-from-interrupt; Wishbone classic register bus.
// Notes:   Function
// Function
// (R1) Sample and resolve requests every cycle.
// (R2) Detect, finish instruction, then five-cycle call.
// (R3) After return, one instruction before next call.
// (R4) Worst case follows from return and instruction.
// (R5) Equal or higher level in service blocks.
// (R6) External 0 vectors 0x0003, cleared on vectoring.
// (R7) External 1 and timers cleared on vectoring.
// (R8) Conversion flag vectors 0x0053, software clears.
// (R9) Per-source enable and priority bits.
// (R10) Global enable off holds requests pending.
// (R11) High preempts low; high never preempted.
// (R12) Higher level first, then lowest position.
// (R13) Still-set flag requests again after return.
// (R14) Vector is three plus eight times position.
// (R15) One call outstanding; nesting at most two.
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module irq_vector_ctrl (
    input  wire logic                            ref_clk,
    input  wire logic                            resetn,
    input  wire logic                            wb_cyc_i,
    input  wire logic                            wb_stb_i,
    input  wire logic                            wb_we_i,
    input  wire logic [7:0]                      wb_adr_i,
    input  wire logic [3:0]                      wb_sel_i,
    input  wire logic [31:0]                     wb_dat_i,
    output logic      [31:0]                     wb_dat_o,
    output logic                                 wb_ack_o,
    input  wire logic [irq_vec_pkg::NSRC-1:0]    srcEvent,
    input  wire logic                            extReqPin0N,
    input  wire logic                            extReqPin1N,
    input  wire logic                            instrDone,
    input  wire logic                            retDone,
    output irq_vec_pkg::call_s                   callOut,
    output logic                                 irqOut
);
    localparam int N = irq_vec_pkg::NSRC;

    logic [N-1:0]  enable_r;
    logic          globalEn_r;
    logic [N-1:0]  priority_r;
    logic [N-1:0]  pending_r;
    logic [1:0]    inService_r;
    logic [2:0]    pinSync0_r;
    logic [2:0]    pinSync1_r;
    logic          pinLvl0_r;
    logic          pinLvl1_r;
    logic          reqValid_r;
    logic          reqHigh_r;
    logic [irq_vec_pkg::IDXW-1:0] reqIdx_r;
    irq_vec_pkg::seq_e seq_r;
    logic [2:0]    callCnt_r;
    logic [irq_vec_pkg::NEV-1:0] evStat_r;
    logic [irq_vec_pkg::NEV-1:0] evEn_r;
    logic [31:0]   rdData_r;
    logic          ack_r;
    irq_vec_pkg::call_s call_r;
    logic          irq_r;

    function automatic logic [irq_vec_pkg::IDXW-1:0] first_set(
        input logic [N-1:0] v);
        logic [irq_vec_pkg::IDXW-1:0] r;
        r = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = k[irq_vec_pkg::IDXW-1:0];
            end
        end
        return r;
    endfunction

    // Bus decode.
    wire           busReq   = wb_cyc_i & wb_stb_i & ~ack_r;
    wire           wrStb    = busReq & wb_we_i;
    wire [31:0]    wMask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0]    wData    = wb_dat_i & wMask;
    wire           wrEnable = wrStb & (wb_adr_i == irq_vec_pkg::OFS_ENABLE);
    wire           wrPrio   = wrStb
                              & (wb_adr_i == irq_vec_pkg::OFS_PRIORITY);
    wire           wrPSet   = wrStb
                              & (wb_adr_i == irq_vec_pkg::OFS_PENDSET);
    wire           wrPClr   = wrStb
                              & (wb_adr_i == irq_vec_pkg::OFS_PENDCLR);
    wire           wrEvClr  = wrStb & (wb_adr_i == irq_vec_pkg::OFS_EVCLR);
    wire           wrEvEn   = wrStb & (wb_adr_i == irq_vec_pkg::OFS_EVEN);
    wire [31:0]    enMerged = ({globalEn_r, 14'h0000, enable_r} & ~wMask)
                              | wData;
    wire [N-1:0]   prMerged = (priority_r & ~wMask[N-1:0])
                              | wData[N-1:0];
    wire [N-1:0]   swSet    = wrPSet ? wData[N-1:0] : '0;
    wire [N-1:0]   swClr    = wrPClr ? wData[N-1:0] : '0;

    // Falling edges of the filtered request pins.
    wire           pinNew0  = (pinSync0_r[1] == pinSync0_r[2])
                              ? pinSync0_r[2] : pinLvl0_r;
    wire           pinNew1  = (pinSync1_r[1] == pinSync1_r[2])
                              ? pinSync1_r[2] : pinLvl1_r;
    wire           pinFall0 = pinLvl0_r & ~pinNew0;
    wire           pinFall1 = pinLvl1_r & ~pinNew1;

    // Eligibility and priority resolution.
    wire [N-1:0]   active   = pending_r & enable_r
                              & {N{globalEn_r}}; // [R9] [R10]
    wire [N-1:0]   actHigh  = active & priority_r;
    wire [N-1:0]   actLow   = active & ~priority_r;
    wire           highOk   = ~inService_r[1]; // [R5] [R11]
    wire           lowOk    = ~inService_r[1] & ~inService_r[0]; // [R5]
    // The winner is found whatever level is in service; the level check
    // sits at the call, so a blocked winner is ready when a return ends.
    wire           anyHigh  = |actHigh;
    wire           anyLow   = |actLow;
    wire [irq_vec_pkg::IDXW-1:0] winIdx = anyHigh ? first_set(actHigh)
                                          : first_set(actLow); // [R12]

    // A call is issued on a finished instruction while the sequencer is
    // free; after a return that is the one instruction which follows it.
    wire           seqFree  = (seq_r == irq_vec_pkg::ST_IDLE)
                              | (seq_r == irq_vec_pkg::ST_RETHOLD);
    wire           levelOk  = (reqHigh_r & highOk) | (~reqHigh_r & lowOk);
    // The registered winner must still be eligible when the call goes out.
    wire           stillOn  = active[reqIdx_r]; // [R10]
    wire           take     = seqFree & instrDone & reqValid_r & stillOn
                              & levelOk; // [R2] [R3] [R15]
    wire [31:0]    vecWide  = 32'(irq_vec_pkg::VEC_BASE)
                              + 32'(reqIdx_r) * irq_vec_pkg::VEC_STRIDE;
    wire [N-1:0]   takeOne  = take ? (N'(1) << reqIdx_r) : '0;
    wire [N-1:0]   hwClr    = takeOne & irq_vec_pkg::HW_CLEAR_MASK;
    wire [N-1:0]   pinSet   = ((N'(pinFall0)) << irq_vec_pkg::EXT0_IDX)
                              | ((N'(pinFall1)) << irq_vec_pkg::EXT1_IDX);
    wire           retSeen  = retDone & (|inService_r);
    wire [irq_vec_pkg::NEV-1:0] evSet = {retSeen, take};
    wire [irq_vec_pkg::NEV-1:0] evClr = wrEvClr
                              ? wData[irq_vec_pkg::NEV-1:0] : '0;
    wire [irq_vec_pkg::NEV-1:0] evNxt = evSet | (evStat_r & ~evClr);

    wire [31:0]    rdMux    =
        (wb_adr_i == irq_vec_pkg::OFS_ENABLE)   ? {globalEn_r, 14'h0000,
                                                   enable_r} :
        (wb_adr_i == irq_vec_pkg::OFS_PRIORITY) ? {15'h0000, priority_r} :
        (wb_adr_i == irq_vec_pkg::OFS_PENDSET)  ? {15'h0000, pending_r} :
        (wb_adr_i == irq_vec_pkg::OFS_STATE)    ? {16'h0000, reqValid_r,
                                                   reqHigh_r, 1'b0,
                                                   reqIdx_r, 4'h0,
                                                   2'(seq_r),
                                                   inService_r} :
        (wb_adr_i == irq_vec_pkg::OFS_EVSTAT)   ? {30'h00000000, evStat_r} :
        (wb_adr_i == irq_vec_pkg::OFS_EVEN)     ? {30'h00000000, evEn_r} :
        32'h00000000;

    // Pending flags, one per source; a set beats a clear.
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_pend
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    pending_r[gi] <= irq_vec_pkg::PENDING_RST[gi];
                end else begin
                    pending_r[gi] <= srcEvent[gi] | swSet[gi] | pinSet[gi]
                        | (pending_r[gi] & ~swClr[gi]
                        & ~hwClr[gi]); // [R6] [R7] [R8] [R13]
                end
            end
        end
    endgenerate

    // Request pin synchronisers and filtered levels.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pinSync0_r <= 3'h7;
            pinSync1_r <= 3'h7;
            pinLvl0_r  <= 1'b1;
            pinLvl1_r  <= 1'b1;
        end else begin
            pinSync0_r <= {pinSync0_r[1:0], extReqPin0N};
            pinSync1_r <= {pinSync1_r[1:0], extReqPin1N};
            pinLvl0_r  <= pinNew0;
            pinLvl1_r  <= pinNew1;
        end
    end

    // Detection stage: winner registered every cycle.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reqValid_r <= 1'b0;
            reqHigh_r  <= 1'b0;
            reqIdx_r   <= '0;
        end else begin
            reqValid_r <= (anyHigh | anyLow) & ~take; // [R1]
            reqHigh_r  <= anyHigh;
            reqIdx_r   <= winIdx;
        end
    end

    // Call sequencer and in-service levels.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            seq_r       <= irq_vec_pkg::ST_IDLE;
            callCnt_r   <= 3'h0;
            inService_r <= 2'b00;
        end else begin
            case (seq_r)
                irq_vec_pkg::ST_IDLE: begin
                    if (take) begin
                        seq_r     <= irq_vec_pkg::ST_CALL;
                        callCnt_r <= irq_vec_pkg::CALL_CYCLES
                                     - 3'h1; // [R2]
                        if (reqHigh_r) begin
                            inService_r[1] <= 1'b1; // [R11] [R15]
                        end else begin
                            inService_r[0] <= 1'b1;
                        end
                    end else if (retSeen) begin
                        seq_r <= irq_vec_pkg::ST_RETHOLD; // [R3] [R4]
                        if (inService_r[1]) begin
                            inService_r[1] <= 1'b0;
                        end else begin
                            inService_r[0] <= 1'b0;
                        end
                    end
                end
                irq_vec_pkg::ST_CALL: begin
                    if (callCnt_r == 3'h0) begin
                        seq_r <= irq_vec_pkg::ST_IDLE;
                    end else begin
                        callCnt_r <= callCnt_r - 3'h1;
                    end
                end
                irq_vec_pkg::ST_RETHOLD: begin
                    if (take) begin
                        seq_r     <= irq_vec_pkg::ST_CALL;
                        callCnt_r <= irq_vec_pkg::CALL_CYCLES
                                     - 3'h1; // [R3] [R4]
                        if (reqHigh_r) begin
                            inService_r[1] <= 1'b1; // [R11] [R15]
                        end else begin
                            inService_r[0] <= 1'b1;
                        end
                    end else if (retSeen) begin
                        if (inService_r[1]) begin
                            inService_r[1] <= 1'b0;
                        end else begin
                            inService_r[0] <= 1'b0;
                        end
                    end else if (instrDone) begin
                        seq_r <= irq_vec_pkg::ST_IDLE; // [R3] [R5] [R13]
                    end
                end
                default: begin
                    seq_r <= irq_vec_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Call output to the core.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            call_r <= '0;
        end else begin
            call_r.req <= take; // [R2] [R15]
            if (take) begin
                call_r.high   <= reqHigh_r;
                call_r.vector <= vecWide[irq_vec_pkg::VECW-1:0]; // [R14]
            end
        end
    end

    // Software-visible configuration.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            enable_r   <= irq_vec_pkg::ENABLE_RST;
            globalEn_r <= 1'b0;
            priority_r <= irq_vec_pkg::PRIORITY_RST;
            evEn_r     <= '0;
        end else begin
            if (wrEnable) begin
                enable_r   <= enMerged[N-1:0]; // [R9]
                globalEn_r <= enMerged[irq_vec_pkg::GLOBAL_EN_BIT]; // [R10]
            end
            if (wrPrio) begin
                priority_r <= prMerged; // [R9]
            end
            if (wrEvEn) begin
                evEn_r <= wData[irq_vec_pkg::NEV-1:0];
            end
        end
    end

    // Event status, interrupt line and bus answer.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            evStat_r <= '0;
            irq_r    <= 1'b0;
            ack_r    <= 1'b0;
            rdData_r <= 32'h00000000;
        end else begin
            evStat_r <= evNxt;
            irq_r    <= |(evNxt & evEn_r);
            ack_r    <= busReq;
            if (busReq) begin
                rdData_r <= wb_we_i ? 32'h00000000 : rdMux;
            end
        end
    end

    assign wb_dat_o = rdData_r;
    assign wb_ack_o = ack_r;
    assign callOut  = call_r;
    assign irqOut   = irq_r;
endmodule

// ===== tb/irq_vector_ctrl_assertions.sv
// Purpose: Port checks for the vector controller.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
module irq_vector_ctrl_checker (
    input wire logic               ref_clk,
    input wire logic               resetn,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    input wire logic               instrDone,
    input wire irq_vec_pkg::call_s callOut
);
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_ack_answer: assert property (take |=> wb_ack_o)
        else $error("ack missing");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(take))
        else $error("ack without request");
    a_dat_hold: assert property (!(wb_cyc_i && wb_stb_i)
        |=> $stable(wb_dat_o)) else $error("read data moved");
    a_call_cause: assert property (callOut.req |-> $past(instrDone))
        else $error("call without retired instruction");
    a_call_busy: assert property (callOut.req |=> !callOut.req [*4])
        else $error("calls too close");
    a_vec_form: assert property (callOut.req |->
        callOut.vector[2:0] == 3'h3 && callOut.vector <= 16'h0083)
        else $error("vector off grid");
    a_vec_hold: assert property (!callOut.req |->
        $stable(callOut.vector) && $stable(callOut.high))
        else $error("vector changed between calls");
endmodule

// ===== tb/core_model.sv
// Purpose: Core sequencer model retiring instructions and calls.
// Assumes: instrLen cycles per instruction, five per call or return.
// Notes:   A doRet pulse turns the next instruction into a return.
`timescale 1ns/1ps
module core_model (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       call,
    input  wire logic       doRet,
    input  wire logic [3:0] instrLen,
    output logic            instrDone,
    output logic            retDone
);
    logic [3:0] cnt_r;
    logic       stall_r;
    logic       retPend_r;
    wire  [3:0] len = (stall_r || retPend_r) ? 4'h5 : instrLen;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            {cnt_r, stall_r, retPend_r, instrDone, retDone} <= '0;
        end else begin
            instrDone <= 1'b0;
            retDone <= 1'b0;
            if (call) begin
                stall_r <= 1'b1;
                cnt_r <= 4'h1;
            end else if (cnt_r != len - 4'h1) begin
                cnt_r <= cnt_r + 4'h1;
            end else begin
                cnt_r <= 4'h0;
                stall_r <= 1'b0;
                if (stall_r) begin
                end else if (retPend_r) begin
                    retDone <= 1'b1;
                    retPend_r <= 1'b0;
                end else begin
                    instrDone <= 1'b1;
                end
            end
            if (doRet) retPend_r <= 1'b1;
        end
    end
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the interrupt vector controller.
// Assumes: Core model retires instructions; classic Wishbone bus.
// Notes:   A monitor queues every call with its high bit and vector.
`timescale 1ns/1ps
module testbench;
    logic        ref_clk, resetn, cyc, stb, we, pin0N, pin1N, doRet;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, datO, allOn;
    logic        ackO, instrDone, retDone, irqOut;
    logic [16:0] srcEvent;
    logic [3:0]  instrLen;
    logic [16:0] calls[$];
    irq_vec_pkg::call_s callOut;
    int          err_count = 0, compares = 0, cycle = 0, tEv, tCall, tRet, n;
    irq_vector_ctrl irq_vector_ctrl_i (
        .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(datO), .wb_ack_o(ackO), .srcEvent(srcEvent),
        .extReqPin0N(pin0N), .extReqPin1N(pin1N), .instrDone(instrDone),
        .retDone(retDone), .callOut(callOut), .irqOut(irqOut));
    core_model core_model_i (.ref_clk(ref_clk), .resetn(resetn),
        .call(callOut.req), .doRet(doRet), .instrLen(instrLen),
        .instrDone(instrDone), .retDone(retDone));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycle++;
        if (srcEvent != '0) tEv = cycle;
        if (retDone === 1'b1) tRet = cycle;
        if (callOut.req === 1'b1) begin
            tCall = cycle;
            calls.push_back({callOut.high, callOut.vector});
        end
    end
    task automatic end_sim;
        $display("Counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge ref_clk); while (ackO !== 1'b1 && ++k < 50);
        if (k >= 50) begin
            chk({31'h0, ackO}, 32'h1);
            end_sim();
        end
        rdat = datO;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic ev(input int i);
        @(posedge ref_clk);
        srcEvent <= 17'h1 << i;
        @(posedge ref_clk);
        srcEvent <= '0;
    endtask
    task automatic take(input logic [16:0] e);
        int k;
        k = 0;
        while (calls.size() == 0 && k++ < 100) @(posedge ref_clk);
        if (calls.size() == 0) begin
            chk(32'hFFFFFFFF, {15'h0, e});
            end_sim();
        end
        chk({15'h0, calls.pop_front()}, {15'h0, e});
    endtask
    task automatic none(input int c);
        repeat (c) @(posedge ref_clk);
        chk(32'(calls.size()), 32'h0);
    endtask
    task automatic ret;
        @(posedge ref_clk);
        doRet <= 1'b1;
        @(posedge ref_clk);
        doRet <= 1'b0;
        repeat (12) @(posedge ref_clk);
    endtask
    initial begin
        {cyc, stb, we, doRet, adr, wdat, srcEvent} = '0;
        {pin0N, pin1N, resetn, instrLen} = {3'b110, 4'h1};
        allOn = (32'h1 << irq_vec_pkg::GLOBAL_EN_BIT) | 32'h1FFFF;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        bus(0, irq_vec_pkg::OFS_PRIORITY, '0);
        chk(rdat, irq_vec_pkg::PRIORITY_RST);
        bus(1, 8'hF0, 32'hFFFFFFFF);
        bus(0, 8'hF0, '0);
        chk(rdat, 32'h0);
        $display("test reset done");
        bus(1, irq_vec_pkg::OFS_ENABLE, allOn);
        for (n = 0; n < 17; n++) begin
            ev(n);
            take(17'(3 + 8 * n));
            if (n == 10) chk(32'(tCall - tEv), 32'h3);
            bus(0, irq_vec_pkg::OFS_PENDSET, '0);
            chk({31'h0, rdat[n]}, 32'(n > 3));
            bus(1, irq_vec_pkg::OFS_PENDCLR, 32'h1 << n);
            ret();
        end
        $display("test vectors done");
        bus(1, irq_vec_pkg::OFS_PENDSET, 32'h220);
        take(17'h0002B);
        none(20);
        bus(1, irq_vec_pkg::OFS_PENDCLR, 32'h20);
        ret();
        take(17'h0004B);
        chk(32'(tCall - tRet), 32'h2);
        bus(1, irq_vec_pkg::OFS_PENDCLR, 32'h200);
        ret();
        bus(1, irq_vec_pkg::OFS_PRIORITY, 32'h200);
        bus(1, irq_vec_pkg::OFS_PENDSET, 32'h220);
        take(17'h1004B);
        ev(0);
        none(20);
        bus(1, irq_vec_pkg::OFS_PENDCLR, 32'h220);
        ret();
        take(17'h00003);
        ev(9);
        take(17'h1004B);
        bus(0, irq_vec_pkg::OFS_STATE, '0);
        chk({30'h0, rdat[1:0]}, 32'h3);
        bus(1, irq_vec_pkg::OFS_PENDCLR, 32'h200);
        ret();
        ret();
        $display("test priority done");
        bus(1, irq_vec_pkg::OFS_ENABLE, allOn & ~32'h40);
        ev(6);
        none(20);
        bus(1, irq_vec_pkg::OFS_ENABLE, 32'h1FFFF);
        none(20);
        instrLen <= 4'h8;
        bus(1, irq_vec_pkg::OFS_ENABLE, allOn);
        take(17'h00033);
        ret();
        take(17'h00033);
        chk(32'(tCall - tRet), 32'h9);
        bus(1, irq_vec_pkg::OFS_PENDCLR, 32'h40);
        ret();
        instrLen <= 4'h1;
        $display("test gating done");
        bus(0, irq_vec_pkg::OFS_EVSTAT, '0);
        chk(rdat, 32'h3);
        chk({31'h0, irqOut}, 32'h0);
        bus(1, irq_vec_pkg::OFS_EVEN, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irqOut}, 32'h1);
        bus(1, irq_vec_pkg::OFS_EVCLR, 32'h3);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irqOut}, 32'h0);
        $display("test irq done");
        pin0N <= 1'b0;
        take(17'h00003);
        ret();
        pin1N <= 1'b0;
        take(17'h00013);
        ret();
        none(20);
        $display("test pins done");
        end_sim();
    end
endmodule
bind irq_vector_ctrl irq_vector_ctrl_checker irq_vector_ctrl_checker_i (
    .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .instrDone(instrDone), .callOut(callOut));
